// >>> hdl/ltcr_regs.sv
// Line transceiver control registers behind an APB slave
//
// Summary of operation
// - Pointer code 0,1 picks channels 0,1; codes 2,3 pick receivers 2,3.
// - Indirect data reads and writes the line length of the pointed unit.
// - Line-length code 000 means E1; codes 011 to 111 mean T1.
// - In T1, codes 011 to 111 pick pulse shape per 133 ft cable band.
// - Line-length readback is inverted by default; a parameter selects it.
// - A set tristate bit puts that transmit driver in high impedance.
// - Alarm status bit is one while that receiver sees an alarm signal.
// - One read of alarm status clears the alarm change flags it saw at setup.
// - Enable bit one lets that receiver's alarm change raise an interrupt.
// - Power-up clears tristate, alarm status and alarm enable registers.
// - Each alarm state change latches a flag until the next clear.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "ltcr_consts.svh"

module ltcr_regs
#(
  parameter int ADDR_W          = 8,
  parameter int NRX             = 4,
  parameter int NTX             = 2,
  parameter bit INVERT_LEN_READ = 1'b1
)
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [NRX-1:0]        ais_detect,
  output logic      [NTX-1:0]        tx_tristate,
  output logic      [3*NRX-1:0]      line_length_code,
  output logic      [NRX-1:0]        rx_e1_mode,
  output logic      [NRX-1:0]        rx_t1_mode,
  output logic                       irq
);
  import ltcr_pkg::*;

  // Parameters the register layout cannot serve
  // Checked at time zero; a bad value prints an error but does not stop the run
  initial
  begin
    if (ADDR_W < 8 || ADDR_W > 32)
      $error("ltcr_regs: ADDR_W must lie in 8..32");
    if (NRX < 2 || NRX > 4)
      $error("ltcr_regs: NRX must lie in 2..4");
    if (NTX < 1 || NTX > 2 || NTX > NRX)
      $error("ltcr_regs: NTX must lie in 1..2 and not exceed NRX");
    if (NRX > (1 << `LTCR_PTR_W))
      $error("ltcr_regs: NRX exceeds what the pointer field can reach");
    if (NRX > `LTCR_REG_W || NTX > `LTCR_REG_W)
      $error("ltcr_regs: unit counts exceed the register width");
  end

  // Register state; every _q except e1_q is cleared by the synchronous reset.
  // Line-length codes live in one array entry per unit, so the
  // indirect port and the flat output bus read the same storage.
  logic [`LTCR_PTR_W-1:0] ptr_q,     ptr_d;
  ltcr_len_t              len_q      [NRX];
  ltcr_len_t              len_d      [NRX];
  logic [NTX-1:0]         tri_q,     tri_d;
  logic [NRX-1:0]         irq_en_q,  irq_en_d;
  logic [NRX-1:0]         snap_q,    snap_d;
  logic [NRX-1:0]         e1_q,      e1_d;
  logic [NRX-1:0]         t1_q,      t1_d;
  logic                   irq_q,     irq_d;
  logic [31:0]            prdata_q,  prdata_d;
  logic                   pready_q,  pready_d;
  logic                   pslverr_q, pslverr_d;

  // Per-receiver alarm tracking
  // Change flags are sticky; only reset, a status read or a write-one clears
  logic [NRX-1:0]         ais_state;
  logic [NRX-1:0]         change_flags;
  logic [NRX-1:0]         change_clr;

  // Bus decode
  // Setup and access phases see the same paddr, so one decode serves both
  logic [5:0]             idx;
  logic                   upper_zero;
  logic                   hit;
  logic                   setup_ph;
  logic                   access_done;
  logic                   wr_en;
  logic                   rd_done;
  logic                   ptr_valid;
  ltcr_byte_t             rbyte;
  ltcr_len_t              len_sel;

  assign idx         = paddr[`LTCR_IDX_MSB:`LTCR_IDX_LSB];
  assign upper_zero  = ((paddr >> 8) == '0) && (paddr[1:0] == 2'b00);
  assign setup_ph    = psel & ~penable;
  assign access_done = psel & penable & pready_q;
  assign wr_en       = access_done & pwrite & ~pslverr_q;
  assign rd_done     = access_done & ~pwrite & ~pslverr_q;
  assign ptr_valid   = (int'(ptr_q) < NRX);

  // Address hit check for the six mapped words
  // Bits above the word index must be zero, or the access is refused
  always_comb
  begin
    hit = 1'b0;
    if (upper_zero)
    begin
      case (idx)
        `LTCR_IDX_SHAPE_SEL,
        `LTCR_IDX_SHAPE_DATA,
        `LTCR_IDX_TRISTATE,
        `LTCR_IDX_AIS_STATUS,
        `LTCR_IDX_AIS_IRQ_EN,
        `LTCR_IDX_AIS_CHANGE: hit = 1'b1;
        default:              hit = 1'b0;
      endcase
    end
  end

  // Pointed unit's code, zero for reserved pointer codes
  // Zero rather than a wrapped unit, so a bad pointer cannot alias
  always_comb
  begin
    len_sel = '0;
    for (int i = 0; i < NRX; i++)
    begin
      if (ptr_valid && int'(ptr_q) == i)
        len_sel = len_q[i];
    end
  end

  // Read mux; reserved and unused bits read zero
  // Status bits are live state; the change flags carry the history
  always_comb
  begin
    rbyte = '0;
    case (idx)
      `LTCR_IDX_SHAPE_SEL:  rbyte[`LTCR_PTR_W-1:0] = ptr_q;
      `LTCR_IDX_SHAPE_DATA:
      begin
        if (ptr_valid)
          rbyte[`LTCR_LEN_W-1:0] = INVERT_LEN_READ ? ~len_sel
                                                   : len_sel;
      end
      `LTCR_IDX_TRISTATE:   rbyte[NTX-1:0] = tri_q;
      `LTCR_IDX_AIS_STATUS: rbyte[NRX-1:0] = ais_state;
      `LTCR_IDX_AIS_IRQ_EN: rbyte[NRX-1:0] = irq_en_q;
      `LTCR_IDX_AIS_CHANGE: rbyte[NRX-1:0] = change_flags;
      default:              rbyte = '0;
    endcase
  end

  // Bus answer: no wait state, yet data and ready leave flip-flops.
  // The answer is formed at setup, so every transfer takes two cycles
  // and the slave never adds a path from paddr to prdata.
  always_comb
  begin
    pready_d  = setup_ph;
    pslverr_d = setup_ph & ~hit;
    prdata_d  = prdata_q;
    if (setup_ph)
      prdata_d = (hit && !pwrite) ? {24'h00_0000, rbyte} : 32'h0000_0000;
  end

  // Flags seen at setup of a status read; only those get cleared,
  // so an alarm change landing mid-transfer survives to the next read
  always_comb
  begin
    snap_d = snap_q;
    if (setup_ph)
      snap_d = (!pwrite && upper_zero && idx == `LTCR_IDX_AIS_STATUS)
               ? change_flags : '0;
  end

  // Clear paths: status read clears all seen flags, or write one to clear
  // Both sources act only on a completed transfer without error
  always_comb
  begin
    change_clr = '0;
    if (rd_done && idx == `LTCR_IDX_AIS_STATUS)
      change_clr = snap_q;
    else if (wr_en && idx == `LTCR_IDX_AIS_CHANGE)
      change_clr = pwdata[NRX-1:0];
  end

  // Register writes
  // A refused transfer never lands here, since wr_en masks the error
  always_comb
  begin
    ptr_d    = ptr_q;
    tri_d    = tri_q;
    irq_en_d = irq_en_q;
    for (int i = 0; i < NRX; i++)
      len_d[i] = len_q[i];
    if (wr_en)
    begin
      case (idx)
        `LTCR_IDX_SHAPE_SEL:  ptr_d = pwdata[`LTCR_PTR_W-1:0];
        `LTCR_IDX_SHAPE_DATA:
        begin
          // Reserved pointer codes drop the write
          for (int i = 0; i < NRX; i++)
          begin
            if (ptr_valid && int'(ptr_q) == i)
              len_d[i] = pwdata[`LTCR_LEN_W-1:0];
          end
        end
        // Upper bits are expected zero and are not stored
        `LTCR_IDX_TRISTATE:   tri_d    = pwdata[NTX-1:0];
        `LTCR_IDX_AIS_IRQ_EN: irq_en_d = pwdata[NRX-1:0];
        default:              ptr_d    = ptr_q;
      endcase
    end
  end

  // Mode decode per unit and interrupt combine
  // Registered so mode pins never glitch while a code is rewritten
  always_comb
  begin
    for (int i = 0; i < NRX; i++)
    begin
      e1_d[i] = (len_q[i] == `LTCR_LEN_E1);
      // Codes 011..111 each pick a 133 ft band shape; 001/010 are neither
      t1_d[i] = (len_q[i] >= `LTCR_LEN_T1_MIN);
    end
    irq_d = |(change_flags & irq_en_q);
  end

  // Register stage for all state
  // Reset gives E1 mode on every unit, matching the zero code
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ptr_q     <= `LTCR_PTR_RST;
      tri_q     <= `LTCR_TRI_RST;
      irq_en_q  <= `LTCR_IRQ_EN_RST;
      snap_q    <= '0;
      e1_q      <= '1;
      t1_q      <= '0;
      irq_q     <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      for (int i = 0; i < NRX; i++)
        len_q[i] <= `LTCR_LEN_RST;
    end
    else
    begin
      ptr_q     <= ptr_d;
      tri_q     <= tri_d;
      irq_en_q  <= irq_en_d;
      snap_q    <= snap_d;
      e1_q      <= e1_d;
      t1_q      <= t1_d;
      irq_q     <= irq_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      for (int i = 0; i < NRX; i++)
        len_q[i] <= len_d[i];
    end
  end

  // One alarm tracker per receiver
  // Trackers run every cycle, independent of bus activity
  for (genvar g = 0; g < NRX; g++)
  begin : g_ais
    ltcr_ais_track u_track
    (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .ais_raw     (ais_detect[g]),
      .clr         (change_clr[g]),
      .ais_state_q (ais_state[g]),
      .change_q    (change_flags[g])
    );
  end

  // Line-length codes leave as one flat bus
  // Unit i sits at bits 3i+2 down to 3i
  always_comb
  begin
    line_length_code = '0;
    for (int i = 0; i < NRX; i++)
      line_length_code[3*i +: 3] = len_q[i];
  end

  // Outputs straight from flip-flops
  // No combinational path from the bus reaches a pin
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign tx_tristate = tri_q;
  assign rx_e1_mode  = e1_q;
  assign rx_t1_mode  = t1_q;
  assign irq         = irq_q;

endmodule : ltcr_regs

// >>> hdl/ltcr_consts.svh
// Register indices, field positions, reset values and bus constants
`ifndef LTCR_CONSTS_SVH
`define LTCR_CONSTS_SVH

// Register indices; byte address is four times the index
`define LTCR_IDX_SHAPE_SEL   6'h10
`define LTCR_IDX_SHAPE_DATA  6'h11
`define LTCR_IDX_TRISTATE    6'h12
`define LTCR_IDX_AIS_STATUS  6'h13
`define LTCR_IDX_AIS_IRQ_EN  6'h14
`define LTCR_IDX_AIS_CHANGE  6'h15

// Field widths and positions
`define LTCR_PTR_W           3
`define LTCR_LEN_W           3
`define LTCR_REG_W           8
`define LTCR_IDX_LSB         2
`define LTCR_IDX_MSB         7

// Reset values
`define LTCR_PTR_RST         3'h0
`define LTCR_LEN_RST         3'h0
`define LTCR_TRI_RST         2'h0
`define LTCR_IRQ_EN_RST      4'h0

// Line-length codes
`define LTCR_LEN_E1          3'h0
`define LTCR_LEN_T1_MIN      3'h3

`endif

// >>> hdl/ltcr_pkg.sv
// Shared types of the line transceiver control register bank
package ltcr_pkg;

  typedef logic [2:0] ltcr_len_t;
  typedef logic [7:0] ltcr_byte_t;

  // Transmit pulse-shape bands and E1 operation
  typedef enum logic [2:0]
  {
    LTCR_E1       = 3'h0,
    LTCR_RSVD1    = 3'h1,
    LTCR_RSVD2    = 3'h2,
    LTCR_T1_0_133 = 3'h3,
    LTCR_T1_266   = 3'h4,
    LTCR_T1_399   = 3'h5,
    LTCR_T1_533   = 3'h6,
    LTCR_T1_655   = 3'h7
  } ltcr_len_e;

endpackage : ltcr_pkg

// >>> hdl/ltcr_ais_track.sv
// Per-receiver alarm state register and sticky change flag
`timescale 1ns/1ps
`include "ltcr_consts.svh"

module ltcr_ais_track
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ais_raw,
  input  wire logic clr,
  output logic      ais_state_q,
  output logic      change_q
);
  import ltcr_pkg::*;

  logic ais_state_d;
  logic change_d;

  // Any edge of the alarm sets the flag; set beats a clear
  always_comb
  begin
    ais_state_d = ais_raw;
    change_d    = (ais_raw != ais_state_q) | (change_q & ~clr);
  end

  // Power-up leaves both clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ais_state_q <= 1'b0;
      change_q    <= 1'b0;
    end
    else
    begin
      ais_state_q <= ais_state_d;
      change_q    <= change_d;
    end
  end

endmodule : ltcr_ais_track

// >>> dv/ltcr_regs_asserts.sv
// Port assertions for the line transceiver register bank
`timescale 1ns/1ps
`include "ltcr_consts.svh"
module ltcr_regs_asserts
#(
  parameter int ADDR_W = 8,
  parameter int NRX    = 4,
  parameter int NTX    = 2
)
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [NRX-1:0]    ais_detect,
  input wire logic [NTX-1:0]    tx_tristate,
  input wire logic [3*NRX-1:0]  line_length_code,
  input wire logic [NRX-1:0]    rx_e1_mode,
  input wire logic [NRX-1:0]    rx_t1_mode,
  input wire logic              irq
);
  import ltcr_pkg::*;
  logic       setup;
  logic       mapped;
  logic [1:0] wd_lo;
  // Setup phase and decode of the six word-aligned registers
  assign setup  = psel && !penable;
  assign mapped = paddr[1:0] == 2'h0 && paddr[7:2] >= `LTCR_IDX_SHAPE_SEL
                  && paddr[7:2] <= `LTCR_IDX_AIS_CHANGE;
  assign wd_lo  = pwdata[1:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Write access completing at this edge
  sequence s_wr(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  // Read access completing at this edge
  sequence s_rd(logic [7:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  a_ready_after_setup: assert property (setup |=> pready && penable)
    else $error("pready missing after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (setup && !mapped |=> pslverr)
    else $error("no error on unmapped access");
  a_read_upper_zero: assert property (pready && !pwrite
    |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0))
    else $error("read data upper bits not zero");
  a_tristate_write: assert property (
    s_wr({`LTCR_IDX_TRISTATE, 2'b00}) |=> tx_tristate == $past(wd_lo))
    else $error("tristate bits do not follow write");
  a_reset_values: assert property (
    $fell(sys_rst) |-> tx_tristate == 2'h0 && !irq && rx_e1_mode == '1)
    else $error("outputs not cleared by reset");
  a_e1_mode_follow: assert property (
    line_length_code[2:0] == 3'h0 |=> rx_e1_mode[0] && !rx_t1_mode[0])
    else $error("code zero did not give E1 mode");
  a_t1_mode_follow: assert property (
    line_length_code[2:0] >= 3'h3 |=> rx_t1_mode[0] && !rx_e1_mode[0])
    else $error("T1 code did not give T1 mode");
  // Status read shows the alarm inputs as registered at setup
  a_status_follow: assert property (
    s_rd({`LTCR_IDX_AIS_STATUS, 2'b00})
    |-> prdata[NRX-1:0] == $past(ais_detect, 2))
    else $error("alarm status read does not follow inputs");
endmodule : ltcr_regs_asserts

bind ltcr_regs ltcr_regs_asserts #(.ADDR_W(ADDR_W), .NRX(NRX), .NTX(NTX))
  u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ais_detect(ais_detect),
    .tx_tristate(tx_tristate), .line_length_code(line_length_code),
    .rx_e1_mode(rx_e1_mode), .rx_t1_mode(rx_t1_mode), .irq(irq));

// >>> dv/tb_line_transceiver_ctrl_regs.sv
// Self-checking bench for the line transceiver register bank
`timescale 1ns/1ps
`include "ltcr_consts.svh"
module tb_line_transceiver_ctrl_regs;
  import ltcr_pkg::*;
  localparam logic [7:0] A_SEL = {`LTCR_IDX_SHAPE_SEL, 2'b00};
  localparam logic [7:0] A_DAT = {`LTCR_IDX_SHAPE_DATA, 2'b00};
  localparam logic [7:0] A_TRI = {`LTCR_IDX_TRISTATE, 2'b00};
  localparam logic [7:0] A_STA = {`LTCR_IDX_AIS_STATUS, 2'b00};
  localparam logic [7:0] A_IEN = {`LTCR_IDX_AIS_IRQ_EN, 2'b00};
  localparam logic [7:0] A_CHG = {`LTCR_IDX_AIS_CHANGE, 2'b00};
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r;}
    ltcr_row_s;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  ais_detect, rx_e1_mode, rx_t1_mode;
  logic [1:0]  tx_tristate;
  logic [11:0] line_length_code;
  int          bad_count, checks;
  // Write then read back; readback of line length comes inverted
  ltcr_row_s   rows [5] = '{'{A_SEL, 8'h02, 8'h02}, '{A_DAT, 8'h03, 8'h04},
    '{A_TRI, 8'h02, 8'h02}, '{A_IEN, 8'h05, 8'h05}, '{A_STA, 8'hFF, 8'h00}};

  ltcr_regs dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ais_detect(ais_detect), .tx_tristate(tx_tristate),
    .line_length_code(line_length_code), .rx_e1_mode(rx_e1_mode),
    .rx_t1_mode(rx_t1_mode), .irq(irq));

  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task test_done();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; pready and read data taken at the rising edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1)
    begin
      bad_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial
  begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    ais_detect = 4'h0;
    bad_count = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("rst_out", 32'h0000_000F, 32'({tx_tristate, line_length_code, irq,
      rx_t1_mode, rx_e1_mode}));
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, A_TRI + 8'(4 * i), 8'h00);
      chk("rst_reg", 32'h0, rd);
    end
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 8'h00);
      chk("row", {24'h0, rows[i].r}, {er, rd[30:0]});
    end
    chk("tristate", 32'h0000_0002, 32'(tx_tristate));
    chk("len_rx2", 32'h0000_0003, 32'(line_length_code[8:6]));
    // Each of pointer codes 0 to 3 gets its own T1 band
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b1, A_SEL, 8'(p));
      apb(1'b1, A_DAT, 8'(7 - p));
      apb(1'b0, A_DAT, 8'h00);
      chk("len_rd", 32'(p), rd);
      chk("len_out", 32'(7 - p), 32'(line_length_code[3*p +: 3]));
    end
    chk("t1_mode", 32'h0000_00F0, 32'({rx_t1_mode, rx_e1_mode}));
    apb(1'b1, A_SEL, 8'h00);
    apb(1'b1, A_DAT, 8'h00);
    repeat (2) @(negedge clk);
    chk("e1_mode", 32'h0000_00E1, 32'({rx_t1_mode, rx_e1_mode}));
    // Reserved code 001 gives neither mode
    apb(1'b1, A_DAT, 8'h01);
    repeat (2) @(negedge clk);
    chk("rsvd_mode", 32'h0000_00E0, 32'({rx_t1_mode, rx_e1_mode}));
    // Pointer beyond the four units reads zero without error
    apb(1'b1, A_SEL, 8'h04);
    apb(1'b0, A_DAT, 8'h00);
    chk("ptr_oob", 32'h0, {er, rd[30:0]});
    apb(1'b0, 8'h58, 8'h00);
    chk("unmapped", 32'h8000_0000, {er, rd[30:0]});
    apb(1'b1, A_TRI + 8'h01, 8'h01);
    chk("misalign", 32'h0000_0006, 32'({er, tx_tristate}));
    // Alarm raise, read-clear, then a masked change and write-one clear
    ais_detect <= 4'h3;
    repeat (4) @(negedge clk);
    chk("irq_on", 32'h0000_0001, 32'(irq));
    apb(1'b0, A_CHG, 8'h00);
    chk("chg", 32'h3, rd);
    apb(1'b0, A_STA, 8'h00);
    chk("status", 32'h3, rd);
    repeat (2) @(negedge clk);
    chk("irq_clr", 32'h0000_0000, 32'(irq));
    apb(1'b0, A_CHG, 8'h00);
    chk("chg_clr", 32'h0, rd);
    ais_detect <= 4'h1;
    repeat (4) @(negedge clk);
    chk("irq_mask", 32'h0000_0000, 32'(irq));
    apb(1'b0, A_CHG, 8'h00);
    chk("chg_mask", 32'h2, rd);
    apb(1'b1, A_CHG, 8'h02);
    apb(1'b0, A_CHG, 8'h00);
    chk("chg_w1c", 32'h0, rd);
    // Reset in mid-run clears the live state again
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("rst_mid", 32'h0000_000F, 32'({tx_tristate, line_length_code, irq,
      rx_t1_mode, rx_e1_mode}));
    apb(1'b0, A_IEN, 8'h00);
    chk("rst_ien", 32'h0, rd);
    test_done();
  end
endmodule : tb_line_transceiver_ctrl_regs
